// file: test/smx_host.sv
// Host model: issues task-file commands and the one-sector payload.
// Assumes every taken F9h command is answered by one DONE pulse; F8h gets none.
`timescale 1ns/1ps
`default_nettype none
module smx_host (
   input wire logic CLOCK,
   input wire logic DONE,
   input wire logic SETMAX_ADDR_CMD,
   output logic CMD_WR,
   output logic [7:0] CMD_OPCODE,
   output logic [7:0] CMD_FEATURE,
   output logic DATA_WR,
   output logic [15:0] DATA_WORD
);
   int done_cnt = 0;
   int setmax_cnt = 0;
   initial begin
      CMD_WR = 1'b0;
      CMD_OPCODE = 8'h00;
      CMD_FEATURE = 8'h00;
      DATA_WR = 1'b0;
      DATA_WORD = 16'h0000;
   end
   always @(posedge CLOCK) begin
      if (DONE === 1'b1) done_cnt <= done_cnt + 1;
      if (SETMAX_ADDR_CMD === 1'b1) setmax_cnt <= setmax_cnt + 1;
   end
   // Filler words change every word so a misplaced compare cannot pass
   task automatic cmd(input logic [7:0] op, input logic [7:0] feat, input bit send,
         input logic [15:0] pw, output bit ok);
      int n;
      int start;
      start = done_cnt;
      @(posedge CLOCK);
      CMD_WR <= 1'b1;
      CMD_OPCODE <= op;
      CMD_FEATURE <= feat;
      @(posedge CLOCK);
      CMD_WR <= 1'b0;
      for (n = 0; send && n < 256; n++) begin
         DATA_WR <= 1'b1;
         DATA_WORD <= (n >= 1 && n <= 16) ? pw + 16'(n) : ~pw ^ 16'(n);
         @(posedge CLOCK);
      end
      DATA_WR <= 1'b0;
      for (n = 0; n < 400 && done_cnt == start; n++) begin
         @(posedge CLOCK);
         #1;
      end
      ok = (done_cnt == start + 1);
   endtask
endmodule // smx_host
`default_nettype wire

// file: test/tb_top.sv
// Testbench: register port tasks and command sequences with expected values.
// Assumes the host model drives the command and payload ports.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic CLOCK = 1'b0;
   logic RST_N = 1'b0;
   logic [3:0] REG_ADDR = 4'h0;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [7:0] REG_WDATA = 8'h00;
   logic CMD_WR, DATA_WR, SETMAX_ADDR_CMD, DONE, IRQ;
   logic [7:0] CMD_OPCODE, CMD_FEATURE, REG_RDATA;
   logic [15:0] DATA_WORD;
   logic [15:0] pw = 16'h5A30;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   bit ok;
   always #20 CLOCK = ~CLOCK;
   smx_lock dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .CMD_WR(CMD_WR), .CMD_OPCODE(CMD_OPCODE),
      .CMD_FEATURE(CMD_FEATURE), .DATA_WR(DATA_WR), .DATA_WORD(DATA_WORD),
      .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .SETMAX_ADDR_CMD(SETMAX_ADDR_CMD), .DONE(DONE), .IRQ(IRQ));
   smx_host host_u (.CLOCK(CLOCK), .DONE(DONE), .SETMAX_ADDR_CMD(SETMAX_ADDR_CMD),
      .CMD_WR(CMD_WR), .CMD_OPCODE(CMD_OPCODE), .CMD_FEATURE(CMD_FEATURE),
      .DATA_WR(DATA_WR), .DATA_WORD(DATA_WORD));
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge CLOCK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLOCK);
      REG_RD <= 1'b0;
      #1;
      chk8($sformatf("reg %h", a), exp, REG_RDATA);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLOCK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLOCK);
      REG_WR <= 1'b0;
   endtask
   // Error and status are only meaningful after an F9h command
   task automatic run(input logic [7:0] op, input logic [7:0] feat, input bit send,
         input logic [15:0] p, input bit abt);
      host_u.cmd(op, feat, send, p, ok);
      // Only F9h belongs to this block; a lone F8h gets no DONE pulse and is checked for none
      chk8("done", {7'h00, op === smx_pkg::OPC_SETMAX}, {7'h00, ok});
      if (op === smx_pkg::OPC_SETMAX) begin
         rd(smx_pkg::REG_ERROR, abt ? 8'h04 : 8'h00);
         rd(smx_pkg::REG_STATUS, abt ? 8'h41 : 8'h40);
      end
   endtask
   task automatic rst;
      RST_N <= 1'b0;
      repeat (4) @(posedge CLOCK);
      RST_N <= 1'b1;
   endtask
   task automatic results;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      int k;
      int sm;
      rst();
      rd(smx_pkg::REG_STATE, 8'hA0);
      rd(4'hF, 8'h00);
      wr(smx_pkg::REG_IRQ_MASK, 8'h02);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_UNLOCK, 0, pw, 1);
      rd(smx_pkg::REG_IRQ_STAT, 8'h03);
      chk8("irq", 8'h01, {7'h00, IRQ});
      wr(smx_pkg::REG_IRQ_STAT, 8'h07);
      rd(smx_pkg::REG_IRQ_STAT, 8'h00);
      chk8("irq", 8'h00, {7'h00, IRQ});
      run(smx_pkg::OPC_SETMAX, 8'h05, 0, pw, 1);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_SETPW, 1, pw, 0);
      rd(smx_pkg::REG_STATE, 8'hB0);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_LOCK, 0, pw, 0);
      rd(smx_pkg::REG_STATE, 8'hB1);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_LOCK, 0, pw, 1);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_SETPW, 0, pw, 1);
      sm = host_u.setmax_cnt;
      run(smx_pkg::OPC_RDNATIVE, 8'h00, 0, pw, 0);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_UNLOCK, 0, pw, 1);
      chk8("setmax", 8'h00, 8'(host_u.setmax_cnt - sm));
      for (k = 0; k < 4; k++) begin
         run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_UNLOCK, 1, ~pw, 1);
         rd(smx_pkg::REG_STATE, {3'(4 - k), 5'h11});
      end
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_UNLOCK, 1, pw, 0);
      rd(smx_pkg::REG_STATE, 8'h30);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_LOCK, 0, pw, 0);
      wr(smx_pkg::REG_IRQ_MASK, 8'h04);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_UNLOCK, 1, ~pw, 1);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_UNLOCK, 0, pw, 1);
      rd(smx_pkg::REG_STATE, 8'h11);
      chk8("irq", 8'h01, {7'h00, IRQ});
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_FREEZE, 0, pw, 0);
      rd(smx_pkg::REG_STATE, 8'h12);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_UNLOCK, 0, pw, 1);
      // Reset is dropped on a rising edge, like every other input
      @(posedge CLOCK);
      rst();
      rd(smx_pkg::REG_STATE, 8'hA0);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_UNLOCK, 0, pw, 1);
      sm = host_u.setmax_cnt;
      run(smx_pkg::OPC_RDNATIVE, 8'h00, 0, pw, 0);
      run(smx_pkg::OPC_SETMAX, smx_pkg::FEAT_LOCK, 0, pw, 0);
      chk8("setmax", 8'h01, 8'(host_u.setmax_cnt - sm));
      rd(smx_pkg::REG_STATE, 8'hA0);
      results();
   end
endmodule // tb_top
`default_nettype wire

// file: verilog/smx_lock.sv
// Lock and unlock subcommand handling for max-address security.
// Assumes task-file writes arrive as one-cycle strobes from same-clock logic.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module smx_lock #(
   parameter int PW_W = 16
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic CMD_WR,
   input wire logic [7:0] CMD_OPCODE,
   input wire logic [7:0] CMD_FEATURE,
   input wire logic DATA_WR,
   input wire logic [PW_W-1:0] DATA_WORD,
   input wire logic [3:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic SETMAX_ADDR_CMD,
   output logic DONE,
   output logic IRQ
);
   typedef enum {S_IDLE, S_XFER, S_FINISH} smx_ph_t;
   smx_pkg::smx_sec_t sec, next_sec;
   smx_ph_t ph, next_ph;
   logic [2:0] tries, next_tries;
   logic [PW_W-1:0] pw [smx_pkg::PW_WORDS];
   logic [PW_W-1:0] next_pw [smx_pkg::PW_WORDS];
   logic pw_set, next_pw_set;
   logic is_setpw, next_is_setpw;
   logic mismatch, next_mismatch;
   logic [7:0] wcnt, next_wcnt;
   logic after_native, next_after_native;
   logic abort, next_abort;
   logic bsy, next_bsy;
   logic drq, next_drq;
   logic done, next_done;
   logic setmax, next_setmax;
   logic [2:0] irq_stat, next_irq_stat;
   logic [2:0] irq_mask, next_irq_mask;
   logic [7:0] rdata, next_rdata;
   logic [2:0] ev;

   function automatic logic in_pw(input logic [7:0] w);
      in_pw = (w >= 8'(smx_pkg::PW_FIRST)) && (w < 8'(smx_pkg::PW_FIRST + smx_pkg::PW_WORDS));
   endfunction

   always_comb begin
      logic [3:0] idx;
      idx = 4'h0;
      next_sec = sec;
      next_ph = ph;
      next_tries = tries;
      next_pw = pw;
      next_pw_set = pw_set;
      next_is_setpw = is_setpw;
      next_mismatch = mismatch;
      next_wcnt = wcnt;
      next_after_native = after_native;
      next_abort = abort;
      next_bsy = bsy;
      next_drq = drq;
      next_done = 1'b0;
      next_setmax = 1'b0;
      ev = smx_pkg::IRQ_NONE;
      unique case (ph)
         S_IDLE: begin
            if (CMD_WR) begin
               next_after_native = (CMD_OPCODE == smx_pkg::OPC_RDNATIVE);
               if (CMD_OPCODE == smx_pkg::OPC_SETMAX) begin
                  next_bsy = 1'b1;
                  next_abort = 1'b0;
                  next_ph = S_FINISH;
                  if (after_native) begin
                     // Handed to the address-setting path; abort if secured
                     next_setmax = (sec == smx_pkg::SEC_UNLOCKED);
                     next_abort = (sec != smx_pkg::SEC_UNLOCKED);
                  end else if (sec == smx_pkg::SEC_FROZEN) begin
                     next_abort = 1'b1;
                  end else if (CMD_FEATURE == smx_pkg::FEAT_LOCK) begin
                     if (sec == smx_pkg::SEC_LOCKED) next_abort = 1'b1;
                     else next_sec = smx_pkg::SEC_LOCKED;
                  end else if (CMD_FEATURE == smx_pkg::FEAT_UNLOCK) begin
                     // Exhausted counter refuses before any data moves
                     if (tries == smx_pkg::TRIES_ZERO || !pw_set) begin
                        next_abort = 1'b1;
                     end else begin
                        next_ph = S_XFER;
                        next_drq = 1'b1;
                        next_wcnt = smx_pkg::BYTE_ZERO;
                        next_mismatch = 1'b0;
                        next_is_setpw = 1'b0;
                     end
                  end else if (CMD_FEATURE == smx_pkg::FEAT_SETPW) begin
                     if (sec != smx_pkg::SEC_UNLOCKED) next_abort = 1'b1;
                     else begin
                        next_ph = S_XFER;
                        next_drq = 1'b1;
                        next_wcnt = smx_pkg::BYTE_ZERO;
                        next_is_setpw = 1'b1;
                     end
                  end else if (CMD_FEATURE == smx_pkg::FEAT_FREEZE) begin
                     next_sec = smx_pkg::SEC_FROZEN;
                  end else begin
                     next_abort = 1'b1;
                  end
               end
            end
         end
         S_XFER: begin
            if (DATA_WR) begin
               idx = 4'(wcnt - 8'(smx_pkg::PW_FIRST));
               if (in_pw(wcnt)) begin
                  if (is_setpw) next_pw[idx] = DATA_WORD;
                  else if (DATA_WORD != pw[idx]) next_mismatch = 1'b1;
               end
               next_wcnt = wcnt + 8'h01;
               if (wcnt == 8'(smx_pkg::SECTOR_WORDS - 1)) begin
                  next_drq = 1'b0;
                  next_ph = S_FINISH;
                  if (is_setpw) next_pw_set = 1'b1;
                  else if (mismatch || (in_pw(wcnt) && DATA_WORD != pw[idx])) begin
                     next_abort = 1'b1;
                     next_tries = tries - 3'h1;
                  end else begin
                     next_sec = smx_pkg::SEC_UNLOCKED;
                  end
               end
            end
         end
         S_FINISH: begin
            next_bsy = 1'b0;
            next_done = 1'b1;
            next_ph = S_IDLE;
            ev[smx_pkg::IRQ_DONE] = 1'b1;
            ev[smx_pkg::IRQ_ABORT] = abort;
            ev[smx_pkg::IRQ_EXHAUST] = abort && (tries == smx_pkg::TRIES_ZERO);
         end
      endcase
   end

   always_comb begin
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_rdata = smx_pkg::BYTE_ZERO;
      if (REG_WR && REG_ADDR == smx_pkg::REG_IRQ_MASK) next_irq_mask = REG_WDATA[2:0];
      if (REG_WR && REG_ADDR == smx_pkg::REG_IRQ_STAT) next_irq_stat = irq_stat & ~REG_WDATA[2:0];
      // New events win over a clear in the same cycle
      next_irq_stat = next_irq_stat | ev;
      if (REG_RD) begin
         unique case (REG_ADDR)
            smx_pkg::REG_ERROR: next_rdata[smx_pkg::ERR_ABT] = abort;
            smx_pkg::REG_STATUS: begin
               next_rdata[smx_pkg::ST_BSY] = bsy;
               next_rdata[smx_pkg::ST_RDY] = 1'b1;
               next_rdata[smx_pkg::ST_DRQ] = drq;
               next_rdata[smx_pkg::ST_ERR] = abort && !bsy;
            end
            smx_pkg::REG_STATE: next_rdata = {tries, pw_set, 2'b00, 2'(sec)};
            smx_pkg::REG_IRQ_STAT: next_rdata = {5'h00, irq_stat};
            smx_pkg::REG_IRQ_MASK: next_rdata = {5'h00, irq_mask};
            default: next_rdata = smx_pkg::BYTE_ZERO;
         endcase
      end
   end

   // Synchronous reset stands for power cycle and hard reset alike
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         sec <= smx_pkg::SEC_UNLOCKED;
         ph <= S_IDLE;
         tries <= smx_pkg::TRIES_INIT;
         for (int i = 0; i < smx_pkg::PW_WORDS; i++) pw[i] <= '0;
         pw_set <= 1'b0;
         is_setpw <= 1'b0;
         mismatch <= 1'b0;
         wcnt <= smx_pkg::BYTE_ZERO;
         after_native <= 1'b0;
         abort <= 1'b0;
         bsy <= 1'b0;
         drq <= 1'b0;
         done <= 1'b0;
         setmax <= 1'b0;
         irq_stat <= smx_pkg::IRQ_NONE;
         irq_mask <= smx_pkg::IRQ_NONE;
         rdata <= smx_pkg::BYTE_ZERO;
      end else begin
         sec <= next_sec;
         ph <= next_ph;
         tries <= next_tries;
         pw <= next_pw;
         pw_set <= next_pw_set;
         is_setpw <= next_is_setpw;
         mismatch <= next_mismatch;
         wcnt <= next_wcnt;
         after_native <= next_after_native;
         abort <= next_abort;
         bsy <= next_bsy;
         drq <= next_drq;
         done <= next_done;
         setmax <= next_setmax;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         rdata <= next_rdata;
      end
   end

   assign REG_RDATA = rdata;
   assign SETMAX_ADDR_CMD = setmax;
   assign DONE = done;
   assign IRQ = |(irq_stat & irq_mask);

   property p_lock_enters;
      @(posedge CLOCK) disable iff (!RST_N)
      (ph == S_IDLE && CMD_WR && CMD_OPCODE == smx_pkg::OPC_SETMAX && !after_native
       && CMD_FEATURE == smx_pkg::FEAT_LOCK && sec == smx_pkg::SEC_UNLOCKED)
      |=> sec == smx_pkg::SEC_LOCKED ##1 done;
   endproperty
   a_lock_enters: assert property (p_lock_enters) else $error("Lock did not lock");

   property p_locked_rejects;
      @(posedge CLOCK) disable iff (!RST_N)
      (ph == S_IDLE && CMD_WR && CMD_OPCODE == smx_pkg::OPC_SETMAX && sec == smx_pkg::SEC_LOCKED
       && (after_native || CMD_FEATURE == smx_pkg::FEAT_LOCK || CMD_FEATURE == smx_pkg::FEAT_SETPW))
      |=> abort && sec == smx_pkg::SEC_LOCKED;
   endproperty
   a_locked_rejects: assert property (p_locked_rejects) else $error("Locked accepted command");

   property p_locked_stays;
      @(posedge CLOCK) disable iff (!RST_N)
      (sec == smx_pkg::SEC_LOCKED && ph == S_IDLE && !CMD_WR) |=> sec == smx_pkg::SEC_LOCKED;
   endproperty
   a_locked_stays: assert property (p_locked_stays) else $error("Locked state left");

   property p_mismatch_counts;
      @(posedge CLOCK) disable iff (!RST_N)
      (ph == S_XFER && !is_setpw && next_abort && !abort)
      |=> tries == $past(tries) - 3'h1 ##1 done && !bsy;
   endproperty
   a_mismatch_counts: assert property (p_mismatch_counts) else $error("Mismatch not counted");

   property p_tries_bounded;
      @(posedge CLOCK) disable iff (!RST_N)
      tries <= smx_pkg::TRIES_INIT && (tries == $past(tries) || tries == $past(tries) - 3'h1);
   endproperty
   a_tries_bounded: assert property (p_tries_bounded) else $error("Attempt counter wrong");

   property p_exhausted;
      @(posedge CLOCK) disable iff (!RST_N)
      (ph == S_IDLE && CMD_WR && CMD_OPCODE == smx_pkg::OPC_SETMAX && !after_native
       && CMD_FEATURE == smx_pkg::FEAT_UNLOCK && tries == smx_pkg::TRIES_ZERO)
      |=> abort && !drq ##1 done;
   endproperty
   a_exhausted: assert property (p_exhausted) else $error("Unlock not refused");

   property p_match_unlocks;
      @(posedge CLOCK) disable iff (!RST_N)
      (ph == S_XFER && !is_setpw && next_ph == S_FINISH && !next_abort)
      |=> sec == smx_pkg::SEC_UNLOCKED;
   endproperty
   a_match_unlocks: assert property (p_match_unlocks) else $error("Match did not unlock");

   property p_abort_flags;
      @(posedge CLOCK) disable iff (!RST_N)
      (ph == S_FINISH && abort) |=> !bsy && abort && irq_stat[smx_pkg::IRQ_ABORT];
   endproperty
   a_abort_flags: assert property (p_abort_flags) else $error("Abort flags wrong");
endmodule // smx_lock
`default_nettype wire

// file: verilog/smx_pkg.sv
// Package for the max-address lock/unlock command block.
// Assumes a single 25 MHz clock domain and a plain register port.
package smx_pkg;
   // Task-file command opcode and feature codes
   localparam logic [7:0] OPC_SETMAX = 8'hF9;
   localparam logic [7:0] OPC_RDNATIVE = 8'hF8;
   localparam logic [7:0] FEAT_SETPW = 8'h01;
   localparam logic [7:0] FEAT_LOCK = 8'h02;
   localparam logic [7:0] FEAT_UNLOCK = 8'h03;
   localparam logic [7:0] FEAT_FREEZE = 8'h04;
   // Attempt counter
   localparam logic [2:0] TRIES_INIT = 3'h5;
   localparam logic [2:0] TRIES_ZERO = 3'h0;
   // Password words per sector payload
   localparam int PW_WORDS = 16;
   localparam int PW_FIRST = 1;
   localparam int SECTOR_WORDS = 256;
   // Register offsets
   localparam logic [3:0] REG_ERROR = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_STATE = 4'h2;
   localparam logic [3:0] REG_IRQ_STAT = 4'h3;
   localparam logic [3:0] REG_IRQ_MASK = 4'h4;
   // Field positions
   localparam int ERR_ABT = 2;
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ABORT = 1;
   localparam int IRQ_EXHAUST = 2;
   localparam logic [2:0] IRQ_NONE = 3'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Security states
   typedef enum logic [1:0] {SEC_UNLOCKED, SEC_LOCKED, SEC_FROZEN} smx_sec_t;
endpackage
